// ===== speir_pkg.sv
// constants for the serial port enable and interrupt register slice
// assumes an 8-bit register port with a 4-bit word address
package speir_pkg;

  localparam int unsigned SPEIR_AW = 4;
  localparam int unsigned SPEIR_DW = 8;

  // register addresses
  localparam logic [3:0] SPEIR_ADDR_MODULE_ENABLE_SECOND = 4'h0;
  localparam logic [3:0] SPEIR_ADDR_INTERRUPT_ENABLE_FIRST = 4'h1;
  localparam logic [3:0] SPEIR_ADDR_INTERRUPT_ENABLE_SECOND = 4'h2;
  localparam logic [3:0] SPEIR_ADDR_INTERRUPT_FLAG_FIRST = 4'h3;
  localparam logic [3:0] SPEIR_ADDR_EVENT_STATUS = 4'h4;
  localparam logic [3:0] SPEIR_ADDR_EVENT_MASK = 4'h5;

  // field positions
  localparam int unsigned SPEIR_BIT_PORT1_TX_ENABLE = 5;
  localparam int unsigned SPEIR_BIT_PORT1_RX_ENABLE = 4;
  localparam int unsigned SPEIR_BIT_PORT0_TX_IRQ_ENABLE = 7;
  localparam int unsigned SPEIR_BIT_PORT0_RX_IRQ_ENABLE = 6;
  localparam int unsigned SPEIR_BIT_PORT1_TX_IRQ_ENABLE = 5;
  localparam int unsigned SPEIR_BIT_PORT1_RX_IRQ_ENABLE = 4;
  localparam int unsigned SPEIR_BIT_PORT0_TX_EMPTY_FLAG = 7;
  localparam int unsigned SPEIR_BIT_PORT0_RX_FULL_FLAG = 6;

  // event status and mask layout
  localparam int unsigned SPEIR_EV_PORT0_TX = 0;
  localparam int unsigned SPEIR_EV_PORT0_RX = 1;
  localparam int unsigned SPEIR_EV_PORT1_TX = 2;
  localparam int unsigned SPEIR_EV_PORT1_RX = 3;
  localparam int unsigned SPEIR_EV_N = 4;

  // values after reset
  localparam logic SPEIR_RST_ENABLE = 1'b0;
  localparam logic SPEIR_RST_TX_EMPTY_FLAG = 1'b1;
  localparam logic SPEIR_RST_RX_FULL_FLAG = 1'b0;
  localparam logic [3:0] SPEIR_RST_EVENTS = 4'h0;
  localparam logic [7:0] SPEIR_RST_RDATA = 8'h00;

endpackage

// ===== speir_regs.sv
// serial port enable and interrupt register slice: enables, interrupt enables,
// first-instance flags, interrupt requests and a masked event interrupt
// assumes single-cycle strobes from the processor and pulses from the serial ports
// Overview of operation
// - Bit 5 of module_enable_second enables the instance one transmitter, reset 0.
// - Bit 4 of module_enable_second enables the instance one receiver, reset 0.
// - Bit 7 of interrupt_enable_first lets the instance zero tx empty flag interrupt, reset 0.
// - Bit 6 of interrupt_enable_first lets the instance zero rx full flag interrupt, reset 0.
// - Bit 5 of interrupt_enable_second enables the instance one tx interrupt, reset 0.
// - Bit 4 of interrupt_enable_second enables the instance one rx interrupt, reset 0.
// - Bit 7 of interrupt_flag_first is set when the instance zero tx buffer is empty, reset 1.
// - Bit 6 of interrupt_flag_first is set when instance zero received a character, reset 0.
// - Bits owned by other modules are not stored, read zero and ignore writes.
// - A write to the instance zero tx holding buffer clears its tx empty flag.
// - A read of instance zero's rx holding buffer clears its rx flag; a read of either instance's pulses the clear of its error and wake bits.
// - While soft reset is set, its instance's irq enables clear, instance zero's rx flag clears and tx flag sets, module enables stay.
`timescale 1ns/1ns
`default_nettype none

module speir_regs
  import speir_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic port0_soft_reset,
  input wire logic port1_soft_reset,
  input wire logic port0_tx_to_shift,
  input wire logic port0_rx_char_done,
  input wire logic port0_tx_holding_buffer_write,
  input wire logic port0_rx_holding_buffer_read,
  input wire logic port1_rx_holding_buffer_read,
  input wire logic port1_tx_empty_flag,
  input wire logic port1_rx_full_flag,
  output logic port1_tx_enable,
  output logic port1_rx_enable,
  output logic port0_tx_empty_flag,
  output logic port0_rx_full_flag,
  output logic port0_tx_irq,
  output logic port0_rx_irq,
  output logic port1_tx_irq,
  output logic port1_rx_irq,
  output logic port0_rx_status_clear,
  output logic port1_rx_status_clear,
  output logic event_irq
);

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target,
                               input logic strobe);
    hit = strobe && (addr == target);
  endfunction

  logic wr_me2;
  logic wr_ie1;
  logic wr_ie2;
  logic wr_interrupt_flag_first;
  logic wr_status;
  logic wr_mask;
  logic port0_tx_irq_enable;
  logic port0_rx_irq_enable;
  logic port1_tx_irq_enable;
  logic port1_rx_irq_enable;
  logic [3:0] event_status;
  logic [3:0] event_mask;
  logic [3:0] event_set;
  logic port1_tx_flag_prev;
  logic port1_rx_flag_prev;
  logic [7:0] next_rdata;

  assign wr_me2 = hit(reg_addr, SPEIR_ADDR_MODULE_ENABLE_SECOND, reg_write);
  assign wr_ie1 = hit(reg_addr, SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, reg_write);
  assign wr_ie2 = hit(reg_addr, SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, reg_write);
  assign wr_interrupt_flag_first = hit(reg_addr, SPEIR_ADDR_INTERRUPT_FLAG_FIRST, reg_write);
  assign wr_status = hit(reg_addr, SPEIR_ADDR_EVENT_STATUS, reg_write);
  assign wr_mask = hit(reg_addr, SPEIR_ADDR_EVENT_MASK, reg_write);

  // module enables: soft reset leaves them alone
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port1_tx_enable <= SPEIR_RST_ENABLE;
      port1_rx_enable <= SPEIR_RST_ENABLE;
    end else if (wr_me2) begin
      port1_tx_enable <= reg_wdata[SPEIR_BIT_PORT1_TX_ENABLE];
      port1_rx_enable <= reg_wdata[SPEIR_BIT_PORT1_RX_ENABLE];
    end
  end

  // instance zero interrupt enables
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port0_tx_irq_enable <= SPEIR_RST_ENABLE;
      port0_rx_irq_enable <= SPEIR_RST_ENABLE;
    end else if (port0_soft_reset) begin
      port0_tx_irq_enable <= 1'b0;
      port0_rx_irq_enable <= 1'b0;
    end else if (wr_ie1) begin
      port0_tx_irq_enable <= reg_wdata[SPEIR_BIT_PORT0_TX_IRQ_ENABLE];
      port0_rx_irq_enable <= reg_wdata[SPEIR_BIT_PORT0_RX_IRQ_ENABLE];
    end
  end

  // instance one interrupt enables
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port1_tx_irq_enable <= SPEIR_RST_ENABLE;
      port1_rx_irq_enable <= SPEIR_RST_ENABLE;
    end else if (port1_soft_reset) begin
      port1_tx_irq_enable <= 1'b0;
      port1_rx_irq_enable <= 1'b0;
    end else if (wr_ie2) begin
      port1_tx_irq_enable <= reg_wdata[SPEIR_BIT_PORT1_TX_IRQ_ENABLE];
      port1_rx_irq_enable <= reg_wdata[SPEIR_BIT_PORT1_RX_IRQ_ENABLE];
    end
  end

  // tx empty flag: hardware set beats every clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port0_tx_empty_flag <= SPEIR_RST_TX_EMPTY_FLAG;
    end else if (port0_soft_reset || port0_tx_to_shift) begin
      port0_tx_empty_flag <= 1'b1;
    end else if (port0_tx_holding_buffer_write) begin
      port0_tx_empty_flag <= 1'b0;
    end else if (wr_interrupt_flag_first) begin
      port0_tx_empty_flag <= reg_wdata[SPEIR_BIT_PORT0_TX_EMPTY_FLAG];
    end
  end

  // rx full flag: soft reset holds it clear, then a received character wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port0_rx_full_flag <= SPEIR_RST_RX_FULL_FLAG;
    end else if (port0_soft_reset) begin
      port0_rx_full_flag <= 1'b0;
    end else if (port0_rx_char_done) begin
      port0_rx_full_flag <= 1'b1;
    end else if (port0_rx_holding_buffer_read) begin
      port0_rx_full_flag <= 1'b0;
    end else if (wr_interrupt_flag_first) begin
      port0_rx_full_flag <= reg_wdata[SPEIR_BIT_PORT0_RX_FULL_FLAG];
    end
  end

  // pulse that tells the port to clear its error and wake bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port0_rx_status_clear <= 1'b0;
      port1_rx_status_clear <= 1'b0;
    end else begin
      port0_rx_status_clear <= port0_rx_holding_buffer_read;
      port1_rx_status_clear <= port1_rx_holding_buffer_read;
    end
  end

  // interrupt requests, registered so they leave from flip-flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port0_tx_irq <= 1'b0;
      port0_rx_irq <= 1'b0;
      port1_tx_irq <= 1'b0;
      port1_rx_irq <= 1'b0;
    end else begin
      port0_tx_irq <= port0_tx_empty_flag && port0_tx_irq_enable;
      port0_rx_irq <= port0_rx_full_flag && port0_rx_irq_enable;
      port1_tx_irq <= port1_tx_empty_flag && port1_tx_irq_enable;
      port1_rx_irq <= port1_rx_full_flag && port1_rx_irq_enable;
    end
  end

  // edge memory for the instance one flags, reset to the flags' own idle levels
  // so that no false edge is seen right after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port1_tx_flag_prev <= SPEIR_RST_TX_EMPTY_FLAG;
      port1_rx_flag_prev <= SPEIR_RST_RX_FULL_FLAG;
    end else begin
      port1_tx_flag_prev <= port1_tx_empty_flag;
      port1_rx_flag_prev <= port1_rx_full_flag;
    end
  end

  always_comb begin
    event_set = SPEIR_RST_EVENTS;
    event_set[SPEIR_EV_PORT0_TX] = port0_tx_to_shift;
    event_set[SPEIR_EV_PORT0_RX] = port0_rx_char_done;
    event_set[SPEIR_EV_PORT1_TX] = port1_tx_empty_flag && !port1_tx_flag_prev;
    event_set[SPEIR_EV_PORT1_RX] = port1_rx_full_flag && !port1_rx_flag_prev;
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_status <= SPEIR_RST_EVENTS;
    end else if (wr_status) begin
      event_status <= (event_status & ~reg_wdata[3:0]) | event_set;
    end else begin
      event_status <= event_status | event_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_mask <= SPEIR_RST_EVENTS;
    end else if (wr_mask) begin
      event_mask <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(event_status & event_mask);
    end
  end

  // read mux: bits of other modules and unmapped addresses read zero
  always_comb begin
    next_rdata = SPEIR_RST_RDATA;
    if (reg_addr == SPEIR_ADDR_MODULE_ENABLE_SECOND) begin
      next_rdata[SPEIR_BIT_PORT1_TX_ENABLE] = port1_tx_enable;
      next_rdata[SPEIR_BIT_PORT1_RX_ENABLE] = port1_rx_enable;
    end else if (reg_addr == SPEIR_ADDR_INTERRUPT_ENABLE_FIRST) begin
      next_rdata[SPEIR_BIT_PORT0_TX_IRQ_ENABLE] = port0_tx_irq_enable;
      next_rdata[SPEIR_BIT_PORT0_RX_IRQ_ENABLE] = port0_rx_irq_enable;
    end else if (reg_addr == SPEIR_ADDR_INTERRUPT_ENABLE_SECOND) begin
      next_rdata[SPEIR_BIT_PORT1_TX_IRQ_ENABLE] = port1_tx_irq_enable;
      next_rdata[SPEIR_BIT_PORT1_RX_IRQ_ENABLE] = port1_rx_irq_enable;
    end else if (reg_addr == SPEIR_ADDR_INTERRUPT_FLAG_FIRST) begin
      next_rdata[SPEIR_BIT_PORT0_TX_EMPTY_FLAG] = port0_tx_empty_flag;
      next_rdata[SPEIR_BIT_PORT0_RX_FULL_FLAG] = port0_rx_full_flag;
    end else if (reg_addr == SPEIR_ADDR_EVENT_STATUS) begin
      next_rdata[3:0] = event_status;
    end else if (reg_addr == SPEIR_ADDR_EVENT_MASK) begin
      next_rdata[3:0] = event_mask;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= SPEIR_RST_RDATA;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= SPEIR_RST_RDATA;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_TX_ENABLE_WRITE: assert property (
    wr_me2 |=> port1_tx_enable == $past(reg_wdata[SPEIR_BIT_PORT1_TX_ENABLE]))
    else $error("port1 tx enable did not follow the write");

  AST_RX_ENABLE_HOLD: assert property (
    !wr_me2 |=> port1_rx_enable == $past(port1_rx_enable))
    else $error("port1 rx enable changed without a write");

  AST_P0_TX_IRQ: assert property (
    port0_tx_empty_flag && port0_tx_irq_enable |=> port0_tx_irq)
    else $error("port0 tx irq missing");

  AST_P0_RX_IRQ_GATED: assert property (
    !port0_rx_irq_enable |=> !port0_rx_irq)
    else $error("port0 rx irq raised while disabled");

  AST_P1_TX_IRQ: assert property (
    port1_tx_irq == $past(port1_tx_empty_flag && port1_tx_irq_enable))
    else $error("port1 tx irq does not match flag and enable");

  AST_P1_RX_IRQ: assert property (
    port1_rx_irq == $past(port1_rx_full_flag && port1_rx_irq_enable))
    else $error("port1 rx irq does not match flag and enable");

  AST_TX_EMPTY_SET: assert property (
    port0_tx_to_shift |=> port0_tx_empty_flag)
    else $error("tx empty flag not set after move to shift");

  AST_RX_FULL_SET: assert property (
    port0_rx_char_done && !port0_soft_reset |=> port0_rx_full_flag)
    else $error("rx full flag not set after character");

  AST_OTHER_BITS_ZERO: assert property (
    reg_read && reg_addr == SPEIR_ADDR_MODULE_ENABLE_SECOND
      |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:0] == 4'h0)
    else $error("bits of other modules read nonzero");

  AST_TX_BUF_CLEAR: assert property (
    port0_tx_holding_buffer_write && !port0_tx_to_shift && !port0_soft_reset
      |=> !port0_tx_empty_flag)
    else $error("tx buffer write did not clear tx empty flag");

  AST_RX_READ_CLEAR: assert property (
    port0_rx_holding_buffer_read && !port0_rx_char_done
      |=> !port0_rx_full_flag && port0_rx_status_clear
        ##1 (!port0_rx_status_clear || $past(port0_rx_holding_buffer_read)))
    else $error("rx buffer read did not clear flag and status");

  AST_SOFT_RESET: assert property (
    port0_soft_reset |=> !port0_tx_irq_enable && !port0_rx_irq_enable
      && port0_tx_empty_flag && !port0_rx_full_flag)
    else $error("soft reset did not force enables and flags");

  AST_FLAG_WRITE: assert property (
    wr_interrupt_flag_first && !port0_soft_reset && !port0_tx_to_shift && !port0_tx_holding_buffer_write
      |=> port0_tx_empty_flag == $past(reg_wdata[7]))
    else $error("software write of tx flag not taken");

  AST_TX_ENABLE_HOLD: assert property (
    !wr_me2 |=> $stable(port1_tx_enable))
    else $error("port1 tx enable changed without a write");

  AST_RX_ENABLE_WRITE: assert property (
    wr_me2 |=> port1_rx_enable == $past(reg_wdata[SPEIR_BIT_PORT1_RX_ENABLE]))
    else $error("port1 rx enable did not follow the write");

  AST_IE1_WRITE: assert property (
    wr_ie1 && !port0_soft_reset
      |=> port0_tx_irq_enable == $past(reg_wdata[SPEIR_BIT_PORT0_TX_IRQ_ENABLE]))
    else $error("port0 tx irq enable did not follow the write");

  AST_IE2_WRITE: assert property (
    wr_ie2 && !port1_soft_reset
      |=> port1_tx_irq_enable == $past(reg_wdata[SPEIR_BIT_PORT1_TX_IRQ_ENABLE]))
    else $error("port1 tx irq enable did not follow the write");

  AST_P1_SOFT_RESET: assert property (
    port1_soft_reset |=> !port1_tx_irq_enable && !port1_rx_irq_enable)
    else $error("port1 soft reset did not clear irq enables");

  AST_P0_RX_IRQ_MATCH: assert property (
    port0_rx_irq == $past(port0_rx_full_flag && port0_rx_irq_enable))
    else $error("port0 rx irq does not match flag and enable");

  AST_P0_TX_IRQ_GATED: assert property (
    !port0_tx_irq_enable |=> !port0_tx_irq)
    else $error("port0 tx irq raised while disabled");

endmodule

`default_nettype wire

// ===== speir_regs_tb.sv
// self-checking bench for the serial port enable and interrupt register slice
// assumes speir_pkg and speir_regs compiled first; one 100 MHz clock
`timescale 1ns/1ns
`default_nettype none

module speir_regs_tb;
  import speir_pkg::*;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic port0_soft_reset = 1'b0;
  logic port1_soft_reset = 1'b0;
  logic [4:0] ev = 5'h00;
  logic port1_tx_empty_flag = 1'b1;
  logic port1_rx_full_flag = 1'b0;
  logic port1_tx_enable, port1_rx_enable, port0_tx_empty_flag, port0_rx_full_flag;
  logic port0_tx_irq, port0_rx_irq, port1_tx_irq, port1_rx_irq;
  logic port0_rx_status_clear, port1_rx_status_clear, event_irq;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] d, got;

  speir_regs speir_regs_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port0_soft_reset(port0_soft_reset), .port1_soft_reset(port1_soft_reset),
    .port0_tx_to_shift(ev[0]), .port0_rx_char_done(ev[1]),
    .port0_tx_holding_buffer_write(ev[2]), .port0_rx_holding_buffer_read(ev[3]),
    .port1_rx_holding_buffer_read(ev[4]), .port1_tx_empty_flag(port1_tx_empty_flag),
    .port1_rx_full_flag(port1_rx_full_flag), .port1_tx_enable(port1_tx_enable),
    .port1_rx_enable(port1_rx_enable), .port0_tx_empty_flag(port0_tx_empty_flag),
    .port0_rx_full_flag(port0_rx_full_flag), .port0_tx_irq(port0_tx_irq),
    .port0_rx_irq(port0_rx_irq), .port1_tx_irq(port1_tx_irq), .port1_rx_irq(port1_rx_irq),
    .port0_rx_status_clear(port0_rx_status_clear),
    .port1_rx_status_clear(port1_rx_status_clear), .event_irq(event_irq)
  );

  always #5 clk = ~clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
    checks = checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string what);
    logic [7:0] v;
    rd(a, v);
    chk(v, e, what);
  endtask

  // one-cycle pulse on a serial event input, sampled just after the taking edge
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    #1;
  endtask

  task automatic settle();
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] irqs_exp(input logic [7:0] ie1, input logic [7:0] ie2,
                                          input logic [7:0] interrupt_flag_first, input logic [1:0] p1f);
    return {4'h0, ie2[4] & p1f[0], ie2[5] & p1f[1], ie1[6] & interrupt_flag_first[6], ie1[7] & interrupt_flag_first[7]};
  endfunction

  initial begin
    void'($urandom(32'h5195d018));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(SPEIR_ADDR_MODULE_ENABLE_SECOND, 8'h00, "me2 reset");
    rdchk(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, 8'h00, "ie1 reset");
    rdchk(SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, 8'h00, "ie2 reset");
    rdchk(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h80, "interrupt_flag_first reset");
    rdchk(4'h9, 8'h00, "unmapped");
    rdchk(SPEIR_ADDR_EVENT_STATUS, 8'h00, "status reset");
    // random enables with foreign bits set: only the serial fields stick
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(SPEIR_ADDR_MODULE_ENABLE_SECOND, d);
      rdchk(SPEIR_ADDR_MODULE_ENABLE_SECOND, d & 8'h30, "me2");
      chk({6'h0, port1_tx_enable, port1_rx_enable}, {6'h0, d[5], d[4]}, "pins");
      wr(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, d);
      rdchk(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, d & 8'hc0, "ie1");
      wr(SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, ~d);
      rdchk(SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, ~d & 8'h30, "ie2");
    end
    // software sets the rx flag and clears both flags
    wr(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h7f);
    rdchk(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h40, "interrupt_flag_first sw");
    wr(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h00);
    rdchk(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h00, "interrupt_flag_first clr");
    pulse(0);
    chk({7'h0, port0_tx_empty_flag}, 8'h01, "tx flag set");
    pulse(2);
    chk({7'h0, port0_tx_empty_flag}, 8'h00, "tx buffer write");
    pulse(1);
    chk({7'h0, port0_rx_full_flag}, 8'h01, "rx flag set");
    pulse(3);
    chk({6'h0, port0_rx_status_clear, port0_rx_full_flag}, 8'h02, "rx read");
    pulse(4);
    chk({7'h0, port1_rx_status_clear}, 8'h01, "port1 rx read");
    // interrupt requests follow flag and enable
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      got = 8'($urandom);
      @(posedge clk);
      port1_tx_empty_flag <= got[1];
      port1_rx_full_flag <= got[0];
      wr(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, got);
      wr(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, d);
      wr(SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, d);
      settle();
      chk({4'h0, port1_rx_irq, port1_tx_irq, port0_rx_irq, port0_tx_irq},
          irqs_exp(d, d, got, got[1:0]), "irqs");
    end
    // soft reset clears irq enables and rx flag, sets tx flag, keeps module enables
    wr(SPEIR_ADDR_MODULE_ENABLE_SECOND, 8'h30);
    wr(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, 8'hc0);
    wr(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h40);
    port0_soft_reset <= 1'b1;
    wr(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, 8'hc0);
    rdchk(SPEIR_ADDR_INTERRUPT_ENABLE_FIRST, 8'h00, "ie1 soft");
    rdchk(SPEIR_ADDR_INTERRUPT_FLAG_FIRST, 8'h80, "interrupt_flag_first soft");
    rdchk(SPEIR_ADDR_MODULE_ENABLE_SECOND, 8'h30, "me2 soft");
    @(posedge clk);
    port0_soft_reset <= 1'b0;
    wr(SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, 8'h30);
    port1_soft_reset <= 1'b1;
    rdchk(SPEIR_ADDR_INTERRUPT_ENABLE_SECOND, 8'h00, "ie2 soft");
    rdchk(SPEIR_ADDR_MODULE_ENABLE_SECOND, 8'h30, "me2 soft1");
    @(posedge clk);
    port1_soft_reset <= 1'b0;
    // event interrupt: raise, mask, unmask, clear; events of earlier tests wiped first
    port1_tx_empty_flag <= 1'b1;
    port1_rx_full_flag <= 1'b0;
    wr(SPEIR_ADDR_EVENT_MASK, 8'h00);
    wr(SPEIR_ADDR_EVENT_STATUS, 8'h0f);
    pulse(0);
    rdchk(SPEIR_ADDR_EVENT_STATUS, 8'h01, "event status");
    chk({7'h0, event_irq}, 8'h00, "event masked");
    wr(SPEIR_ADDR_EVENT_MASK, 8'h01);
    settle();
    chk({7'h0, event_irq}, 8'h01, "event raised");
    wr(SPEIR_ADDR_EVENT_STATUS, 8'h01);
    settle();
    chk({7'h0, event_irq}, 8'h00, "event cleared");
    rdchk(SPEIR_ADDR_EVENT_STATUS, 8'h00, "status cleared");
    // a rising instance one rx flag is a sticky event of its own
    @(posedge clk);
    port1_rx_full_flag <= 1'b1;
    settle();
    rdchk(SPEIR_ADDR_EVENT_STATUS, 8'h08, "port1 rx rise");
    report_and_stop();
  end

endmodule

`default_nettype wire
